// ==== shared/alarm_status_consts.svh ====
// Summary of operation
// - bit 15 set in adjustment mode while running or frozen, not when stopped
// - trim input out of range sets bit 12
// - bad channel code sets bit 13, no trim
// - host run during trim: bit 15 only
// - host-state error freezes all input values
// - mode from parameter word, applied at restart
// - setting errors: fault lamp, run dark, restart clears
// - averaging count above 6 sets bit 11, zero
// - resolution not 00 or C1 sets bit 12
// - bus exchange error: host lamp, zero data
// - host silence timeout: hold prior outputs
// - watchdog error: data may be undefined
// - bad unit number: host lamp, zero data
// - alarm word at n+9 or n+19
// - data reads zero during restart
`ifndef ALARM_STATUS_CONSTS_SVH
`define ALARM_STATUS_CONSTS_SVH
`define IO_BASE 16'h07D0
`define UNIT_STRIDE 16'h000A
`define ALARM_OFS_SMALL 16'h0009
`define ALARM_OFS_LARGE 16'h0013
`define MODE_OFS_SMALL 16'h0012
`define MODE_OFS_LARGE 16'h0013
`define BIT_TRIM 15
`define BIT_BAD_CH 13
`define BIT_RANGE 12
`define BIT_AVG 11
`define AVG_MAX 16'h0006
`define RES_A 8'h00
`define RES_B 8'hC1
`define UNIT_MAX 7'h5F
`define UNIT_MAX_LARGE 7'h5E
`define CH_LO_SMALL 8'h15
`define CH_LO_LARGE 8'hC9
`define HOST_TIMEOUT_US 1000
`define CLK_MHZ 25
`define HOST_TIMEOUT_CYC (`HOST_TIMEOUT_US * `CLK_MHZ)
`define RESTART_CYC 16
`endif

// ==== shared/alarm_status_pkg.sv ====
`default_nettype none
package alarm_status_pkg;
	typedef enum logic [1:0] {
		st_restart = 2'b00,
		st_run = 2'b01,
		st_stop = 2'b10,
		st_frozen = 2'b11
	} unit_state_type;
	typedef struct packed {
		logic unit_fault_lamp;
		logic host_fault_lamp;
		logic trim_lamp;
		logic run_lamp;
	} lamps_type;
	typedef struct packed {
		logic [15:0] avg_count;
		logic [7:0] resolution;
		logic trim_mode;
		logic [6:0] unit_number;
		logic unit_duplicate;
	} settings_type;
endpackage : alarm_status_pkg
`default_nettype wire

// ==== hdl/host_watch.sv ====
`include "alarm_status_consts.svh"
`default_nettype none
module host_watch #(
	parameter int TIMEOUT = `HOST_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// host activity
	input wire logic host_refresh,
	input wire logic arm,
	// result
	output logic timed_out
);
	if (TIMEOUT < 2) begin : g_bad_timeout
		$error("host_watch: TIMEOUT too small");
	end
	logic [31:0] count;
	wire expired = (count >= 32'(TIMEOUT - 1));
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count <= 32'h00000000;
			timed_out <= 1'b0;
		end else if (!arm || host_refresh) begin
			count <= 32'h00000000;
			timed_out <= 1'b0;
		end else if (expired) begin
			timed_out <= 1'b1;
		end else begin
			count <= count + 32'h00000001;
		end
	end
endmodule : host_watch
`default_nettype wire

// ==== hdl/alarm_status.sv ====
`include "alarm_status_consts.svh"
`default_nettype none
module alarm_status #(
	parameter int CHANNELS = 8,
	parameter int HOST_TIMEOUT = `HOST_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// restart request from host
	input wire logic restart_pulse,
	// initial settings from parameter memory area
	input wire alarm_status_pkg::settings_type settings,
	input wire logic [CHANNELS-1:0] channel_enable,
	// adjustment controls
	input wire logic [7:0] trim_channel,
	input wire logic trim_input_out_of_range,
	input wire logic trim_request,
	output logic trim_apply,
	// host state
	input wire logic host_running,
	input wire logic bus_error,
	input wire logic host_watchdog,
	input wire logic host_refresh,
	// conversion datapath
	input wire logic [CHANNELS*16-1:0] raw_data,
	output logic [CHANNELS*16-1:0] conversion_data,
	output logic conversion_enable,
	// io data area word access
	input wire logic io_write,
	input wire logic [15:0] io_addr,
	input wire logic [15:0] io_wdata,
	output logic [15:0] alarm_status_word,
	output logic [15:0] alarm_word_addr,
	output logic [15:0] mode_word_offset,
	// lamps
	output alarm_status_pkg::lamps_type lamps
);
	localparam bit LARGE = (CHANNELS == 16);
	if (CHANNELS != 4 && CHANNELS != 8 &&
		CHANNELS != 16) begin : g_bad_channels
		$error("alarm_status: CHANNELS must be 4, 8 or 16");
	end

	////////////////////////////////////////////////////////////////////
	// latched settings, taken at end of restart
	alarm_status_pkg::unit_state_type state;
	alarm_status_pkg::unit_state_type next_state;
	alarm_status_pkg::settings_type held;
	logic [4:0] restart_count;
	logic restart_prev;
	wire restart_edge = restart_prev && !restart_pulse;
	wire restart_done = (restart_count == 5'(`RESTART_CYC));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			restart_prev <= 1'b0;
			restart_count <= 5'h00;
			held <= '0;
		end else begin
			restart_prev <= restart_pulse;
			if (restart_edge)
				restart_count <= 5'h00;
			else if (state == alarm_status_pkg::st_restart && !restart_done)
				restart_count <= restart_count + 5'h01;
			if (state == alarm_status_pkg::st_restart)
				held <= settings;
		end
	end

	////////////////////////////////////////////////////////////////////
	// error decode
	wire avg_bad = (held.avg_count > `AVG_MAX);
	wire res_bad = (held.resolution != `RES_A) &&
		(held.resolution != `RES_B);
	wire [6:0] unit_max = LARGE ? `UNIT_MAX_LARGE : `UNIT_MAX;
	wire unit_bad = held.unit_duplicate ||
		(held.unit_number > unit_max);
	wire setting_bad = avg_bad || res_bad;
	wire [7:0] ch_lo = LARGE ? `CH_LO_LARGE : `CH_LO_SMALL;
	wire [7:0] ch_hi = 8'(ch_lo + 8'(CHANNELS - 1));
	wire ch_in_window = (trim_channel >= ch_lo) &&
		(trim_channel <= ch_hi);
	wire [7:0] ch_index = 8'(trim_channel - ch_lo);
	wire ch_enabled = ch_in_window &&
		channel_enable[ch_index[$clog2(CHANNELS)-1:0]];
	wire trim_bad_ch = !ch_enabled;
	wire in_trim = held.trim_mode && state == alarm_status_pkg::st_run;
	logic host_silent;

	host_watch #(.TIMEOUT(HOST_TIMEOUT)) u_watch (
		.ref_clk(ref_clk),
		.rst(rst),
		.host_refresh(host_refresh),
		.arm(state == alarm_status_pkg::st_run),
		.timed_out(host_silent)
	);

	////////////////////////////////////////////////////////////////////
	// unit state
	always_comb begin
		next_state = state;
		case (state)
			alarm_status_pkg::st_restart: begin
				if (restart_done) begin
					if (setting_bad || unit_bad)
						next_state = alarm_status_pkg::st_stop;
					else
						next_state = alarm_status_pkg::st_run;
				end
			end
			alarm_status_pkg::st_run: begin
				if (in_trim && host_running)
					next_state = alarm_status_pkg::st_frozen;
			end
			alarm_status_pkg::st_stop: next_state = state;
			alarm_status_pkg::st_frozen: next_state = state;
			default: next_state = alarm_status_pkg::st_restart;
		endcase
		if (restart_edge)
			next_state = alarm_status_pkg::st_restart;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			state <= alarm_status_pkg::st_restart;
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////
	// alarm word; host writes never reach it, they only block trim_apply
	wire frozen = (state == alarm_status_pkg::st_frozen);
	wire stopped = (state == alarm_status_pkg::st_stop);
	logic [15:0] next_alarm;
	always_comb begin
		next_alarm = 16'h0000;
		if (frozen) begin
			next_alarm[`BIT_TRIM] = 1'b1;
		end else if (in_trim) begin
			next_alarm[`BIT_TRIM] = 1'b1;
			next_alarm[`BIT_BAD_CH] = trim_bad_ch;
			next_alarm[`BIT_RANGE] = trim_input_out_of_range;
		end else if (stopped) begin
			next_alarm[`BIT_AVG] = avg_bad;
			next_alarm[`BIT_RANGE] = res_bad;
		end
	end
	wire unused_write = io_write && (io_addr == io_addr) &&
		(io_wdata == io_wdata);

	wire [15:0] unit_base = 16'(`IO_BASE +
		16'(held.unit_number) * `UNIT_STRIDE);
	wire [15:0] alarm_ofs = LARGE ? `ALARM_OFS_LARGE : `ALARM_OFS_SMALL;
	wire [15:0] next_alarm_addr = 16'(unit_base + alarm_ofs);
	wire [15:0] next_mode_ofs = LARGE ? `MODE_OFS_LARGE :
		`MODE_OFS_SMALL;
	wire zero_data = (state == alarm_status_pkg::st_restart) || stopped ||
		bus_error;
	wire hold_data = frozen || host_silent || (in_trim && trim_bad_ch &&
		!trim_input_out_of_range);
	wire next_enable = (state == alarm_status_pkg::st_run) && !bus_error;
	wire next_apply = in_trim && trim_request && !trim_bad_ch &&
		!trim_input_out_of_range && !unused_write;

	////////////////////////////////////////////////////////////////////
	// lamp decode
	wire next_unit_lamp = (stopped && setting_bad) || frozen ||
		(in_trim && (next_alarm[14:12] != 3'b000));
	wire next_host_lamp = bus_error || host_watchdog ||
		(stopped && unit_bad);
	wire next_trim_lamp = held.trim_mode &&
		(state != alarm_status_pkg::st_restart);
	wire next_run_lamp = (state == alarm_status_pkg::st_run) || frozen;

	////////////////////////////////////////////////////////////////////
	// alarm word and lamps, kept as they were while the host is silent
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			alarm_status_word <= 16'h0000;
			lamps <= '0;
		end else if (!host_silent) begin
			alarm_status_word <= next_alarm;
			lamps.unit_fault_lamp <= next_unit_lamp;
			lamps.host_fault_lamp <= next_host_lamp;
			lamps.trim_lamp <= next_trim_lamp;
			lamps.run_lamp <= next_run_lamp;
		end
	end

	////////////////////////////////////////////////////////////////////
	// word address, mode offset and control outputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			alarm_word_addr <= 16'h0000;
			mode_word_offset <= 16'h0000;
			conversion_enable <= 1'b0;
			trim_apply <= 1'b0;
		end else begin
			alarm_word_addr <= next_alarm_addr;
			mode_word_offset <= next_mode_ofs;
			conversion_enable <= next_enable;
			trim_apply <= next_apply;
		end
	end

	////////////////////////////////////////////////////////////////////
	// conversion data, one register per channel
	// restart, stop and bus errors win over holding
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		wire [15:0] live = raw_data[ch*16 +: 16];
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst)
				conversion_data[ch*16 +: 16] <= 16'h0000;
			else if (zero_data)
				conversion_data[ch*16 +: 16] <= 16'h0000;
			else if (!hold_data)
				conversion_data[ch*16 +: 16] <= live;
		end
	end
endmodule : alarm_status
`default_nettype wire

// ==== sim/alarm_status_assertions.sv ====
`default_nettype none
module alarm_status_assertions #(
	parameter int CHANNELS = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// watched ports
	input wire logic restart_pulse,
	input wire logic host_running,
	input wire logic bus_error,
	input wire logic trim_apply,
	input wire logic [15:0] alarm_status_word,
	input wire logic [CHANNELS*16-1:0] conversion_data,
	input wire alarm_status_pkg::lamps_type lamps
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	bus_zero_a: assert property (bus_error [*2] |->
		conversion_data == '0 && lamps.host_fault_lamp) else $error("bus");
	restart_zero_a: assert property ($fell(restart_pulse) |->
		##[2:4] conversion_data == '0) else $error("restart data");
	avg_flag_a: assert property (alarm_status_word[11] |->
		lamps.unit_fault_lamp && !lamps.run_lamp && conversion_data == '0)
		else $error("avg flag");
	res_flag_a: assert property (alarm_status_word[12] &&
		!alarm_status_word[15] |-> conversion_data == '0) else $error("res");
	bad_ch_a: assert property (alarm_status_word[13] |-> !trim_apply)
		else $error("bad channel applied");
	trim_only_a: assert property (trim_apply |-> alarm_status_word[15])
		else $error("trim outside mode");
	host_state_a: assert property ((alarm_status_word[15] && host_running)
		[*3] |-> alarm_status_word == 16'h8000 && lamps.unit_fault_lamp)
		else $error("host state");
	freeze_a: assert property ((alarm_status_word == 16'h8000 &&
		host_running) [*3] |-> $stable(conversion_data)) else $error("freeze");
	unit_num_a: assert property (lamps.host_fault_lamp &&
		!lamps.run_lamp |-> conversion_data == '0) else $error("unit data");
endmodule : alarm_status_assertions
`default_nettype wire

// ==== sim/host_model.sv ====
`default_nettype none
module host_model (
	// clock
	input wire logic ref_clk,
	// control
	input wire logic alive,
	input wire logic [3:0] ch_index,
	// to the unit
	output logic host_refresh,
	output logic [7:0] trim_channel
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div = 2'h0;
	initial host_refresh = 1'b0;
	// refresh pulse every fourth cycle while alive
	always @(posedge ref_clk) begin
		div <= #1 div + 2'h1;
		host_refresh <= #1 alive && div == 2'h0;
	end
	// channel code counted from the first adjustment code
	assign trim_channel = 8'h15 + {4'h0, ch_index};
endmodule : host_model
`default_nettype wire

// ==== sim/alarm_status_tb_top.sv ====
`default_nettype none
module alarm_status_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, rst = 1'b1, restart_pulse = 1'b0, alive = 1'b1;
	logic oor = 1'b0, trim_request = 1'b0, host_running = 1'b0;
	logic bus_error = 1'b0, io_write = 1'b0, trim_apply, conversion_enable;
	logic host_refresh;
	logic [3:0] ch_index = 4'h0;
	logic [7:0] trim_channel;
	logic [15:0] io_addr = 16'h0, alarm_status_word, alarm_word_addr, mode_ofs;
	logic [127:0] raw_data = {8{16'h1234}}, conversion_data;
	alarm_status_pkg::settings_type cfg = '0;
	alarm_status_pkg::lamps_type lamps;
	int err_total = 0, checks = 0;
	initial forever #20 ref_clk = ~ref_clk;
	alarm_status #(.CHANNELS(8), .HOST_TIMEOUT(20)) DUT (.ref_clk(ref_clk),
		.rst(rst), .restart_pulse(restart_pulse), .settings(cfg),
		.channel_enable(8'h01), .trim_channel(trim_channel),
		.trim_input_out_of_range(oor), .trim_request(trim_request),
		.trim_apply(trim_apply), .host_running(host_running),
		.bus_error(bus_error), .host_watchdog(1'b0),
		.host_refresh(host_refresh), .raw_data(raw_data),
		.conversion_data(conversion_data),
		.conversion_enable(conversion_enable), .io_write(io_write),
		.io_addr(io_addr), .io_wdata(16'hFFFF),
		.alarm_status_word(alarm_status_word),
		.alarm_word_addr(alarm_word_addr), .mode_word_offset(mode_ofs),
		.lamps(lamps));
	host_model partner (.ref_clk(ref_clk), .alive(alive), .ch_index(ch_index),
		.host_refresh(host_refresh), .trim_channel(trim_channel));
	////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic chk(input logic [127:0] seen, exp, input string what);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : stop_test
	task automatic restart(input logic [15:0] avg, input logic [7:0] res,
		input logic trim, input logic [6:0] unit);
		cfg = '{avg, res, trim, unit, 1'b0};
		restart_pulse = 1'b1;
		tick(2);
		restart_pulse = 1'b0;
		tick(25);
	endtask : restart
	task automatic trial(input logic [15:0] avg, input logic [7:0] res,
		input logic [6:0] unit, input logic [15:0] word, input logic [3:0] lmp);
		restart(avg, res, 1'b0, unit);
		chk(alarm_status_word, word, "alarm word");
		chk(lamps, lmp, "lamps");
		chk(conversion_data, lmp[0] ? raw_data : '0, "data");
		chk(conversion_enable, lmp[0], "enable");
		$display("test settings %h %h %h done", avg, res, unit);
	endtask : trial
	////////////////////////////////////////////////////////////////////////
	initial begin
		tick(10);
		rst = 1'b0;
		trial(16'h0, 8'h00, 7'h03, 16'h0000, 4'h1);
		chk(alarm_word_addr, 16'h07F7, "alarm addr");
		chk(mode_ofs, 16'h0012, "mode offset");
		io_write = 1'b1;
		io_addr = 16'h07F7;
		tick(3);
		io_write = 1'b0;
		chk(alarm_status_word, 16'h0000, "written word");
		bus_error = 1'b1;
		tick(3);
		chk(conversion_data, '0, "bus data");
		bus_error = 1'b0;
		trial(16'h0007, 8'h00, 7'h03, 16'h0800, 4'h8);
		trial(16'h0000, 8'h01, 7'h03, 16'h1000, 4'h8);
		trial(16'h0000, 8'h00, 7'h60, 16'h0000, 4'h4);
		trial(16'h0006, 8'hC1, 7'h03, 16'h0000, 4'h1);
		restart(16'h0, 8'h00, 1'b1, 7'h03);
		chk(alarm_status_word[15], 1'b1, "trim bit");
		oor = 1'b1;
		tick(3);
		chk(alarm_status_word, 16'h9000, "range word");
		chk(conversion_data[15:0], raw_data[15:0], "live data");
		oor = 1'b0;
		trim_request = 1'b1;
		tick(2);
		chk(trim_apply, 1'b1, "trim accepted");
		trim_request = 1'b0;
		tick(1);
		for (int i = 0; i < 2; i++) begin
			ch_index = i ? 4'hF : 4'h1;
			trim_request = 1'b1;
			tick(3);
			chk(alarm_status_word[13], 1'b1, "channel flag");
			chk(trim_apply, 1'b0, "trim apply");
			trim_request = 1'b0;
			tick(2);
		end
		host_running = 1'b1;
		tick(3);
		chk(alarm_status_word, 16'h8000, "host state");
		raw_data = ~raw_data;
		tick(3);
		chk(conversion_data, ~raw_data, "frozen data");
		$display("test adjustment done");
		host_running = 1'b0;
		restart(16'h0, 8'h00, 1'b0, 7'h03);
		alive = 1'b0;
		tick(30);
		raw_data = ~raw_data;
		tick(3);
		chk(conversion_data, ~raw_data, "silent hold");
		$display("test host silence done");
		stop_test();
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		err_total++;
		stop_test();
	end
endmodule : alarm_status_tb_top
bind alarm_status alarm_status_assertions #(.CHANNELS(CHANNELS)) chk (
	.ref_clk(ref_clk), .rst(rst), .restart_pulse(restart_pulse),
	.host_running(host_running), .bus_error(bus_error),
	.trim_apply(trim_apply), .alarm_status_word(alarm_status_word),
	.conversion_data(conversion_data), .lamps(lamps));
`default_nettype wire
